/* File: hw/tsc_map.svh */
`ifndef TSC_MAP_SVH
`define TSC_MAP_SVH
// Register indices; byte address is four times the index
`define TSC_IDX_CTRL    12'h2C0
`define TSC_IDX_FLAGS   12'h2C8
`define TSC_IDX_STATE   12'h2C9
`define TSC_IDX_RELOAD  12'h2CA
`define TSC_IDX_SEC     12'h2CB
`define TSC_IDX_DEST    12'h2CE
`define TSC_IDX_BUF     12'h2D0
`define TSC_IDX_PRIM    12'h2D2
`define TSC_IDX_PEN0    12'h2DC
`define TSC_IDX_PEN1    12'h2DD
`define TSC_IDX_PEN2    12'h2DE
`define TSC_IDX_ICLR    12'h2E0
`define TSC_IDX_IEN     12'h2E1
`define TSC_IDX_DATA2   12'h2E2
// Reset values
`define TSC_RELOAD_RST  5'h07
`define TSC_SEC_RST     5'h07
// Sequencer states
`define TSC_ST_IDLE     5'h00
`define TSC_ST_LOAD     5'h03
`define TSC_ST_MAIN1    5'h09
`define TSC_ST_MAIN2    5'h12
`define TSC_ST_OVF      5'h15
`define TSC_ST_IRQ      5'h19
// Limits
`define TSC_PRIM_MAX    9'h1FF
`define TSC_NUM_CH      18
// Flag bit positions
`define TSC_FLAG_DONE   0
`define TSC_FLAG_OVF    1
`endif

/* File: hw/tsc_pkg.sv */
package tsc_pkg;
  // Control register fields, most significant first
  typedef struct packed {
    logic [4:0] channel;
    logic       start;
    logic       init;
    logic       enable;
  } tsc_ctrl_type;

  typedef struct packed {
    logic ovf;
    logic done;
  } tsc_flags_type;
endpackage

/* File: hw/tsc_top.sv */
`timescale 1ns/1ps
`include "tsc_map.svh"
// Overview of operation
// - The state counter returns to zero when the end-of-measurement interrupt is acknowledged.
// - Writing one to the initialise bit forces the state counter to zero.
// - Clearing the start bit freezes the state counter at its current value.
// - The state counter sits in bits 0 to 4 of a read/write register, upper bits read zero.
// - A five-bit read/write reload register holds the secondary start value and resets to seven.
// - The read-only secondary counter is loaded from the reload register in state three and resets to seven.
// - A twelve-bit read/write destination address register has bits 12 to 15 reading zero.
// - The primary count is captured into a nine-bit read-only buffer when the first result is fixed.
// - The primary counter is a nine-bit read-only counter topping out at all ones.
// - A primary overflow sets the overflow error flag and jumps the sequencer to state 21.
// - Eighteen channel enables in three registers choose port use (0) or touch sensing (1).
// - Channel enables take effect only while the unit operation enable bit is one.
// - Every channel is measured regardless of its enable, the result then being marked invalid.
// - In step two the secondary counter rises on low samples, falls on high, never above the reload.
// - Results are the primary count at the first low and where the secondary counter reaches zero.
module tsc_top
  import tsc_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [13:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Sensor side
  input  wire logic        sense_level,
  output logic [17:0]      sense_pin_en,
  // Interrupt
  input  wire logic        irq_ack,
  output logic             irq
);

  logic [11:0]   idx;
  logic          wr_en;
  logic          rd_setup;
  logic [31:0]   rd_data;
  logic          rd_hit;
  tsc_ctrl_type  ctrl_reg;
  tsc_flags_type flags_reg;
  tsc_flags_type ien_reg;
  logic [4:0]    state_reg;
  logic [4:0]    reload_reg;
  logic [4:0]    sec_reg;
  logic [11:0]   dest_reg;
  logic [8:0]    buf_reg;
  logic [8:0]    data2_reg;
  logic          invalid_reg;
  logic [8:0]    prim_reg;
  logic [17:0]   pen_reg;
  logic          sync1_reg;
  logic          sync2_reg;
  logic          run;
  logic          low;
  logic          prim_inc;
  logic          ovf_ev;
  logic          done_ev;
  logic          init_wr;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    hit = (a == r);
  endfunction

  assign idx      = paddr[13:2];
  assign pready   = 1'b1;
  assign wr_en    = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;
  assign init_wr  = wr_en & hit(idx, `TSC_IDX_CTRL) & pwdata[1];
  assign run      = ctrl_reg.enable & ctrl_reg.start;
  assign low      = ~sync2_reg;

  // Pin level is asynchronous to pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= sense_level;
      sync2_reg <= sync1_reg;
    end
  end

  // Read mux; unassigned bits are padded with zero
  always_comb begin
    rd_data = 32'h0;
    rd_hit  = 1'b1;
    if (hit(idx, `TSC_IDX_CTRL)) begin
      rd_data = {24'h0, ctrl_reg.channel, ctrl_reg.start, 1'b0, ctrl_reg.enable};
    end else if (hit(idx, `TSC_IDX_FLAGS)) begin
      rd_data = {29'h0, invalid_reg, flags_reg};
    end else if (hit(idx, `TSC_IDX_STATE)) begin
      rd_data = {27'h0, state_reg};
    end else if (hit(idx, `TSC_IDX_RELOAD)) begin
      rd_data = {27'h0, reload_reg};
    end else if (hit(idx, `TSC_IDX_SEC)) begin
      rd_data = {27'h0, sec_reg};
    end else if (hit(idx, `TSC_IDX_DEST)) begin
      rd_data = {20'h0, dest_reg};
    end else if (hit(idx, `TSC_IDX_BUF)) begin
      rd_data = {23'h0, buf_reg};
    end else if (hit(idx, `TSC_IDX_PRIM)) begin
      rd_data = {23'h0, prim_reg};
    end else if (hit(idx, `TSC_IDX_PEN0)) begin
      rd_data = {24'h0, pen_reg[7:0]};
    end else if (hit(idx, `TSC_IDX_PEN1)) begin
      rd_data = {24'h0, pen_reg[15:8]};
    end else if (hit(idx, `TSC_IDX_PEN2)) begin
      rd_data = {30'h0, pen_reg[17:16]};
    end else if (hit(idx, `TSC_IDX_ICLR)) begin
      rd_data = 32'h0;
    end else if (hit(idx, `TSC_IDX_IEN)) begin
      rd_data = {30'h0, ien_reg};
    end else if (hit(idx, `TSC_IDX_DATA2)) begin
      rd_data = {23'h0, data2_reg};
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Read data is captured in setup so the access phase needs no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else if (rd_setup) begin
      prdata  <= pwrite ? 32'h0 : rd_data;
      pslverr <= ~rd_hit;
    end
  end

  // Initialise is a strobe and never reads back as one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= '0;
    end else if (wr_en && hit(idx, `TSC_IDX_CTRL)) begin
      ctrl_reg <= {pwdata[7:2], 1'b0, pwdata[0]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_reg <= `TSC_RELOAD_RST;
      dest_reg   <= 12'h000;
      pen_reg    <= 18'h00000;
      ien_reg    <= '0;
    end else if (wr_en) begin
      if (hit(idx, `TSC_IDX_RELOAD)) begin
        reload_reg <= pwdata[4:0];
      end else if (hit(idx, `TSC_IDX_DEST)) begin
        dest_reg <= pwdata[11:0];
      end else if (hit(idx, `TSC_IDX_PEN0)) begin
        pen_reg[7:0] <= pwdata[7:0];
      end else if (hit(idx, `TSC_IDX_PEN1)) begin
        pen_reg[15:8] <= pwdata[7:0];
      end else if (hit(idx, `TSC_IDX_PEN2)) begin
        pen_reg[17:16] <= pwdata[1:0];
      end else if (hit(idx, `TSC_IDX_IEN)) begin
        ien_reg <= pwdata[1:0];
      end
    end
  end

  // Pins go to the sensor only while the unit is enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense_pin_en <= 18'h00000;
    end else begin
      sense_pin_en <= ctrl_reg.enable ? pen_reg : 18'h00000;
    end
  end

  assign prim_inc = run && sync2_reg && (state_reg == `TSC_ST_MAIN1 || state_reg == `TSC_ST_MAIN2);
  assign ovf_ev   = prim_inc && (prim_reg == `TSC_PRIM_MAX);
  assign done_ev  = run && (state_reg == `TSC_ST_IRQ - 5'h01);

  // Sequencer; when start is low the count holds except on init, a state write or an interrupt acknowledge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= `TSC_ST_IDLE;
    end else if (init_wr) begin
      state_reg <= `TSC_ST_IDLE;
    end else if (wr_en && hit(idx, `TSC_IDX_STATE)) begin
      state_reg <= pwdata[4:0];
    end else if (irq_ack && state_reg == `TSC_ST_IRQ) begin
      state_reg <= `TSC_ST_IDLE;
    end else if (run) begin
      if (ovf_ev) begin
        state_reg <= `TSC_ST_OVF;
      end else if (state_reg == `TSC_ST_MAIN1) begin
        state_reg <= low ? state_reg + 5'h01 : state_reg;
      end else if (state_reg == `TSC_ST_MAIN2) begin
        state_reg <= (sec_reg == 5'h00) ? state_reg + 5'h01 : state_reg;
      end else if (state_reg != `TSC_ST_IRQ) begin
        state_reg <= state_reg + 5'h01;
      end
    end
  end

  // Primary counter saturates; overflow is reported instead of wrapping
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prim_reg <= 9'h000;
    end else if (init_wr || (run && state_reg == `TSC_ST_LOAD)) begin
      prim_reg <= 9'h000;
    end else if (prim_inc && !ovf_ev) begin
      prim_reg <= prim_reg + 9'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_reg <= `TSC_SEC_RST;
    end else if (run && state_reg == `TSC_ST_LOAD) begin
      sec_reg <= reload_reg;
    end else if (run && state_reg == `TSC_ST_MAIN2 && sec_reg != 5'h00) begin
      if (low && sec_reg < reload_reg) begin
        sec_reg <= sec_reg + 5'h01;
      end else if (!low) begin
        sec_reg <= sec_reg - 5'h01;
      end
    end
  end

  // Results; an unenabled channel is still measured but flagged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_reg     <= 9'h000;
      data2_reg   <= 9'h000;
      invalid_reg <= 1'b0;
    end else if (run) begin
      if (state_reg == `TSC_ST_MAIN1 && low) begin
        buf_reg     <= prim_reg;
        // An index past the last channel has no enable bit and counts as invalid
        invalid_reg <= (ctrl_reg.channel > 5'h11) | ~pen_reg[ctrl_reg.channel];
      end
      if (state_reg == `TSC_ST_MAIN2 && sec_reg == 5'h00) begin
        data2_reg <= prim_reg;
      end
    end
  end

  // Sticky flags; a new event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg <= '0;
    end else begin
      if (ovf_ev) begin
        flags_reg.ovf <= 1'b1;
      end else if (init_wr || (wr_en && hit(idx, `TSC_IDX_ICLR) && pwdata[`TSC_FLAG_OVF])) begin
        flags_reg.ovf <= 1'b0;
      end
      if (done_ev) begin
        flags_reg.done <= 1'b1;
      end else if (init_wr || (wr_en && hit(idx, `TSC_IDX_ICLR) && pwdata[`TSC_FLAG_DONE])) begin
        flags_reg.done <= 1'b0;
      end
    end
  end

  assign irq = |(flags_reg & ien_reg);

  state_ack_a: assert property (@(posedge pclk) disable iff (!presetn)
    irq_ack && state_reg == `TSC_ST_IRQ && !init_wr && !(wr_en && hit(idx, `TSC_IDX_STATE))
    |=> state_reg == `TSC_ST_IDLE)
    else $error("state not cleared on ack");

  init_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    init_wr |=> state_reg == 5'h00 && prim_reg == 9'h000)
    else $error("init did not clear");

  stop_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !run && !wr_en && !irq_ack |=> $stable(state_reg))
    else $error("state moved while stopped");

  reload_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    run && state_reg == `TSC_ST_LOAD |=> sec_reg == $past(reload_reg))
    else $error("secondary not loaded");

  sec_cap_a: assert property (@(posedge pclk) disable iff (!presetn)
    sec_reg <= reload_reg |=> sec_reg <= reload_reg || $changed(reload_reg) || $past(run && state_reg == 5'h03))
    else $error("secondary above reload");

  buf_cap_a: assert property (@(posedge pclk) disable iff (!presetn)
    run && state_reg == `TSC_ST_MAIN1 && low |=> buf_reg == $past(prim_reg) && state_reg == 5'h0A)
    else $error("buffer not captured");

  ovf_jump_a: assert property (@(posedge pclk) disable iff (!presetn)
    ovf_ev && !init_wr && !(wr_en && hit(idx, `TSC_IDX_STATE))
    |=> state_reg == 5'h15 && flags_reg.ovf && (irq || !ien_reg.ovf))
    else $error("overflow not handled");

  prim_max_a: assert property (@(posedge pclk) disable iff (!presetn)
    prim_reg == 9'h1FF |=> prim_reg == 9'h1FF || prim_reg == 9'h000)
    else $error("primary wrapped");

  pin_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_reg.enable |=> sense_pin_en == 18'h00000)
    else $error("pins enabled while unit off");

  data2_cap_a: assert property (@(posedge pclk) disable iff (!presetn)
    run && state_reg == `TSC_ST_MAIN2 && sec_reg == 5'h00 |=> data2_reg == $past(prim_reg))
    else $error("second result not captured");

  unused_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_setup |=> prdata[31:12] == 20'h00000)
    else $error("unassigned read bits set");

  state_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && hit(idx, `TSC_IDX_STATE) |=> state_reg == $past(pwdata[4:0]))
    else $error("state write lost");

  reload_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && hit(idx, `TSC_IDX_RELOAD) |=> reload_reg == $past(pwdata[4:0]))
    else $error("reload write lost");

  dest_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && hit(idx, `TSC_IDX_DEST) |=> dest_reg == $past(pwdata[11:0]))
    else $error("destination write lost");

  sec_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(run && (state_reg == `TSC_ST_LOAD || state_reg == `TSC_ST_MAIN2)) |=> $stable(sec_reg))
    else $error("secondary moved outside its states");

  sec_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    run && state_reg == `TSC_ST_MAIN2 && sec_reg != 5'h00 && !low |=> sec_reg == $past(sec_reg) - 5'h01)
    else $error("secondary not decremented");

  pen_apply_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg.enable |=> sense_pin_en == $past(pen_reg))
    else $error("channel enables not applied");

  invalid_mark_a: assert property (@(posedge pclk) disable iff (!presetn)
    run && state_reg == `TSC_ST_MAIN1 && low && ctrl_reg.channel < 5'h12
    |=> invalid_reg == !$past(pen_reg[ctrl_reg.channel]))
    else $error("invalid mark wrong");

endmodule

/* File: test/tsc_electrode.sv */
`timescale 1ns/1ps
module tsc_electrode (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Bench control
  input  wire logic        restart,
  input  wire logic [15:0] high_len,
  // Sensor pin
  output logic             sense_level
);
  logic [15:0] cnt_reg;
  // Saturates so that a long charge never wraps back to high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_reg <= 16'h0000;
    else if (restart) cnt_reg <= 16'h0000;
    else if (cnt_reg != 16'hFFFF) cnt_reg <= cnt_reg + 16'h0001;
  end
  // Charged electrode reads high, then discharges and reads low
  assign sense_level = (cnt_reg < high_len);
endmodule

/* File: test/tb_tsc_top.sv */
`timescale 1ns/1ps
`include "tsc_map.svh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_total++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_tsc_top;
  import tsc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, irq_ack, restart;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, sense_level, irq;
  logic [17:0] sense_pin_en;
  logic [15:0] high_len;
  int          err_total, comparisons;
  tsc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .sense_level(sense_level), .sense_pin_en(sense_pin_en), .irq_ack(irq_ack), .irq(irq));
  tsc_electrode PART (.pclk(pclk), .presetn(presetn), .restart(restart), .high_len(high_len),
    .sense_level(sense_level));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= wr; paddr <= {idx, 2'b00}; pwdata <= wd; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (pready !== 1'b1) begin
      err_total++;
      $display("[FAIL] t=%0t no pready", $time);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, idx, d, r, e);
  endtask
  task automatic rdchk(input logic [11:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, idx, 32'h0, r, e);
    `CHK(r, exp)
  endtask
  function automatic logic [31:0] ctl(input logic en, input logic st, input logic it);
    tsc_ctrl_type c;
    c = '0;
    c.enable = en;
    c.start = st;
    c.init = it;
    return {24'h000000, c};
  endfunction
  task automatic wait_state(input logic [4:0] s);
    int          n;
    logic [31:0] d;
    logic        e;
    n = 0;
    do begin
      apb(1'b0, `TSC_IDX_STATE, 32'h0, d, e);
      n++;
    end while (d[4:0] !== s && n < 3000);
    `CHK(d[4:0], s)
  endtask
  task automatic pulse_restart(input logic [15:0] len);
    @(posedge pclk);
    high_len <= len; restart <= 1'b1;
    @(posedge pclk);
    restart <= 1'b0;
  endtask
  task automatic t_reset;
    rdchk(`TSC_IDX_STATE, 32'h0);
    rdchk(`TSC_IDX_RELOAD, 32'h7);
    rdchk(`TSC_IDX_SEC, 32'h7);
    rdchk(`TSC_IDX_DEST, 32'h0);
    rdchk(`TSC_IDX_PEN1, 32'h0);
    `CHK(sense_pin_en, 18'h00000)
  endtask
  task automatic t_regs;
    logic [31:0] r;
    logic        e;
    logic [11:0] idx [9] = '{`TSC_IDX_STATE, `TSC_IDX_RELOAD, `TSC_IDX_DEST, `TSC_IDX_PEN0,
      `TSC_IDX_PEN1, `TSC_IDX_PEN2, `TSC_IDX_SEC, `TSC_IDX_BUF, `TSC_IDX_PRIM};
    logic [31:0] exp [9] = '{32'h1F, 32'h1F, 32'hFFF, 32'hFF, 32'hFF, 32'h3, 32'h7, 32'h0, 32'h0};
    foreach (idx[i]) wr(idx[i], 32'hFFFFFFFF);
    foreach (idx[i]) rdchk(idx[i], exp[i]);
    `CHK(sense_pin_en, 18'h00000)
    wr(`TSC_IDX_CTRL, ctl(1'b1, 1'b0, 1'b0));
    repeat (2) @(posedge pclk);
    `CHK(sense_pin_en, 18'h3FFFF)
    wr(`TSC_IDX_PEN1, 32'h5A);
    repeat (2) @(posedge pclk);
    `CHK(sense_pin_en, {2'b11, 8'h5A, 8'hFF})
    apb(1'b0, 12'h3FF, 32'h0, r, e);
    `CHK({e, r}, {1'b1, 32'h0})
    rdchk(`TSC_IDX_STATE, 32'h1F);
    wr(`TSC_IDX_CTRL, ctl(1'b1, 1'b0, 1'b1));
    rdchk(`TSC_IDX_STATE, 32'h0);
  endtask
  task automatic t_overflow;
    wr(`TSC_IDX_RELOAD, 32'h0A);
    wr(`TSC_IDX_IEN, 32'h1);
    pulse_restart(16'hFFFF);
    wr(`TSC_IDX_CTRL, ctl(1'b1, 1'b1, 1'b0));
    wait_state(`TSC_ST_IRQ);
    rdchk(`TSC_IDX_PRIM, 32'h1FF);
    rdchk(`TSC_IDX_SEC, 32'h0A);
    `CHK(irq, 1'b1)
    wr(`TSC_IDX_IEN, 32'h0);
    @(posedge pclk);
    `CHK(irq, 1'b0)
    wr(`TSC_IDX_IEN, 32'h3);
    rdchk(`TSC_IDX_FLAGS, 32'h3);
    wr(`TSC_IDX_CTRL, ctl(1'b1, 1'b0, 1'b0));
    rdchk(`TSC_IDX_STATE, {27'h0, `TSC_ST_IRQ});
    @(posedge pclk);
    irq_ack <= 1'b1;
    @(posedge pclk);
    irq_ack <= 1'b0;
    rdchk(`TSC_IDX_STATE, 32'h0);
    wr(`TSC_IDX_ICLR, 32'h3);
    @(posedge pclk);
    `CHK(irq, 1'b0)
  endtask
  task automatic t_low;
    wr(`TSC_IDX_RELOAD, 32'h03);
    pulse_restart(16'h0000);
    // Channel 8 has its enable off, so the result is flagged invalid
    wr(`TSC_IDX_CTRL, ctl(1'b1, 1'b1, 1'b0) | 32'h40);
    wait_state(`TSC_ST_MAIN2);
    rdchk(`TSC_IDX_SEC, 32'h03);
    rdchk(`TSC_IDX_BUF, 32'h0);
    rdchk(`TSC_IDX_FLAGS, 32'h4);
    wr(`TSC_IDX_CTRL, ctl(1'b1, 1'b0, 1'b0));
    rdchk(`TSC_IDX_STATE, {27'h0, `TSC_ST_MAIN2});
    // Three high samples bring the secondary from three down to zero
    pulse_restart(16'h0040);
    wr(`TSC_IDX_CTRL, ctl(1'b1, 1'b1, 1'b0));
    wait_state(`TSC_ST_IRQ);
    rdchk(`TSC_IDX_DATA2, 32'h03);
    rdchk(`TSC_IDX_SEC, 32'h00);
    `CHK(irq, 1'b1)
    wr(`TSC_IDX_CTRL, ctl(1'b1, 1'b0, 1'b1));
    rdchk(`TSC_IDX_STATE, 32'h0);
    `CHK(irq, 1'b0)
  endtask
  task automatic tally_and_finish;
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    // Whole run needs under 1000 cycles; allow plenty of margin
    #200000;
    err_total++;
    tally_and_finish();
  end
  initial begin
    err_total = 0; comparisons = 0;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 14'h0000;
    pwdata = 32'h0; irq_ack = 1'b0; restart = 1'b0; high_len = 16'hFFFF;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_regs();
    t_overflow();
    t_low();
    tally_and_finish();
  end
endmodule
